// file: rtl/line_pattern_gen.sv
// Drives the USB data line pair for the line test patterns
`timescale 1ns/100ps
`include "usb_misc_defines.svh"
module line_pattern_gen (
  // Clock and reset
  input  wire logic                    clk_sys_in,
  input  wire logic                    rstn_in,
  // Selected pattern
  input  wire usb_misc_pkg::line_mode_t mode_in,
  // Line pair
  output logic                         usb_data_plus_line_out,
  output logic                         usb_data_minus_line_out,
  output logic                         usb_data_plus_line_oe_n_out,
  output logic                         usb_data_minus_line_oe_n_out,
  output logic                         quiescent_nak_out
);
  logic [6:0] lfsr_r;
  logic [6:0] lfsr_nxt;
  logic       pos_r;
  logic       pos_nxt;
  logic       neg_r;
  logic       neg_nxt;
  logic       oe_n_r;
  logic       oe_n_nxt;
  logic       nak_r;
  logic       nak_nxt;

  // ========================================
  // Pattern selection
  always_comb begin
    lfsr_nxt = lfsr_r;
    pos_nxt  = 1'b0;
    neg_nxt  = 1'b0;
    oe_n_nxt = 1'b0;
    nak_nxt  = 1'b0;
    unique case (mode_in)
      usb_misc_pkg::LINE_IDLE: begin
        oe_n_nxt = 1'b1;
      end
      usb_misc_pkg::LINE_NAK: begin
        nak_nxt = 1'b1;
      end
      usb_misc_pkg::LINE_J: begin
        pos_nxt = 1'b1;
      end
      usb_misc_pkg::LINE_K: begin
        neg_nxt = 1'b1;
      end
      usb_misc_pkg::LINE_PSEUDO_RANDOM_PATTERN: begin
        // PRBS7, advances only while selected
        lfsr_nxt = {lfsr_r[5:0], lfsr_r[6] ^ lfsr_r[5]};
        pos_nxt  = lfsr_r[6];
        neg_nxt  = ~lfsr_r[6];
      end
      default: begin
        oe_n_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lfsr_r <= `PSEUDO_RANDOM_PATTERN_SEED;
      pos_r  <= 1'b0;
      neg_r  <= 1'b0;
      oe_n_r <= 1'b1;
      nak_r  <= 1'b0;
    end else begin
      lfsr_r <= lfsr_nxt;
      pos_r  <= pos_nxt;
      neg_r  <= neg_nxt;
      oe_n_r <= oe_n_nxt;
      nak_r  <= nak_nxt;
    end
  end

  assign usb_data_plus_line_out       = pos_r;
  assign usb_data_minus_line_out      = neg_r;
  assign usb_data_plus_line_oe_n_out  = oe_n_r;
  assign usb_data_minus_line_oe_n_out = oe_n_r;
  assign quiescent_nak_out            = nak_r;

  // ========================================
  // Checks
  AST_PSEUDO_RANDOM_PATTERN_DIFF : assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    mode_in == usb_misc_pkg::LINE_PSEUDO_RANDOM_PATTERN |=> (pos_r != neg_r) && !oe_n_r && (lfsr_r != 7'h00))
    else $error("PSEUDO_RANDOM_PATTERN pattern not differential or stuck");
  AST_PSEUDO_RANDOM_PATTERN_TOGGLES : assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (mode_in == usb_misc_pkg::LINE_PSEUDO_RANDOM_PATTERN) [*8] |-> !$stable(lfsr_r))
    else $error("PSEUDO_RANDOM_PATTERN generator does not advance");
endmodule : line_pattern_gen

// file: rtl/usb_misc_defines.svh
// Register map, field positions, reset values and timing for the misc register bank
`ifndef USB_MISC_DEFINES_SVH
`define USB_MISC_DEFINES_SVH
// ========================================
// Register map
`define ADDR_W            10
`define OFS_SCRATCH       10'h278
`define OFS_UNLOCK        10'h27c
`define OFS_PULSE_W       10'h280
`define OFS_TEST          10'h284
`define OFS_STATUS        10'h288
// ========================================
// Values
`define UNLOCK_KEY        16'haa37
`define SCRATCH_RST       16'h0000
`define PULSE_W_RST       16'h001e
`define TEST_RST          8'h00
`define TEST_WR_MASK      8'h9f
`define TEST_BUSRST_KEEP  8'h90
`define RDATA_ZERO        32'h0000_0000
// ========================================
// Test and status register bits
`define TEST_FORCE_HS     7
`define TEST_FORCE_FS     4
`define TEST_PSEUDO_RANDOM_PATTERN         3
`define TEST_K            2
`define TEST_J            1
`define TEST_NAK          0
`define STATUS_LOCK       0
// ========================================
// Timing
`define CLK_PERIOD_NS     10
`define PULSE_UNIT_PS     3330
`define CLK_PERIOD_PS     (`CLK_PERIOD_NS * 1000)
// ========================================
// Line pattern generator
`define PSEUDO_RANDOM_PATTERN_SEED         7'h7f
`endif

// file: rtl/usb_misc_pkg.sv
// Types shared by the misc register bank and the line pattern generator
package usb_misc_pkg;
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

  typedef enum logic [2:0] {
    LINE_IDLE = 3'b000,
    LINE_NAK  = 3'b001,
    LINE_J    = 3'b010,
    LINE_K    = 3'b011,
    LINE_PSEUDO_RANDOM_PATTERN = 3'b100
  } line_mode_t;
endpackage : usb_misc_pkg

// file: rtl/usb_misc_regs.sv
// Misc register bank: scratch, write lock, interrupt pulse width, line test control
`timescale 1ns/100ps
`include "usb_misc_defines.svh"
// Behaviour
// - A 16-bit scratch store in two bytes clears at power-on and survives a USB bus reset.
// - Entering suspend locks out register writes.
// - Writing 16'haa37 to the write-only unlock register releases the write lock.
// - In pulse mode each interrupt pulse lasts as long as the pulse width register sets.
// - One width unit is 3.33 ns and a value of 1 gives the shortest pulse.
// - Test bit 7 forces high-speed only and disables chirp detection.
// - Test bit 4 forces full-speed only and disables chirp detection.
// - Test bit 3 toggles the data lines in a pseudo-random pattern.
// - Test bit 2 drives the K state and test bit 1 drives the J state.
// - Test bit 0 puts the lines in the quiescent state and only NAKs high-speed IN tokens.
module usb_misc_regs (
  // Clock and reset
  input  wire logic                clk_sys_in,
  input  wire logic                rstn_in,
  // Avalon-MM slave
  input  wire logic [`ADDR_W-1:0]  avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [31:0]         avs_writedata_in,
  input  wire logic [3:0]          avs_byteenable_in,
  output logic      [31:0]         avs_readdata_out,
  output logic                     avs_waitrequest_out,
  // USB bus state
  input  wire logic                suspend_in,
  input  wire logic                bus_reset_in,
  // Interrupt
  input  wire logic                irq_request_in,
  input  wire logic                irq_pulse_mode_in,
  output logic                     irq_out,
  // Speed control
  output logic                     force_high_speed_out,
  output logic                     force_full_speed_out,
  output logic                     chirp_detect_enable_out,
  output logic                     writes_locked_out,
  // Line test
  output logic                     quiescent_nak_out,
  output logic                     usb_data_plus_line_out,
  output logic                     usb_data_minus_line_out,
  output logic                     usb_data_plus_line_oe_n_out,
  output logic                     usb_data_minus_line_oe_n_out
);
  usb_misc_pkg::bus_state_t state_r;
  usb_misc_pkg::bus_state_t state_nxt;
  usb_misc_pkg::line_mode_t mode_r;
  usb_misc_pkg::line_mode_t mode_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        wait_r;
  logic        wait_nxt;
  logic [15:0] scratch_r;
  logic [15:0] scratch_nxt;
  logic [15:0] width_r;
  logic [15:0] width_nxt;
  logic [7:0]  test_r;
  logic [7:0]  test_nxt;
  logic        locked_r;
  logic        locked_nxt;
  logic        susp_d_r;
  logic        chirp_r;
  logic        chirp_nxt;
  logic        wr_ack;
  logic        susp_rise;
  logic        key_hit;

  assign wr_ack    = (state_r == usb_misc_pkg::BUS_ACK) && avs_write_in;
  assign susp_rise = suspend_in && !susp_d_r;
  assign key_hit   = (avs_address_in == `OFS_UNLOCK) && (avs_byteenable_in[1:0] == 2'b11)
                     && (avs_writedata_in[15:0] == `UNLOCK_KEY);

  // ========================================
  // Bus handshake and read data
  // One wait cycle: request seen, answer registered, waitrequest drops for one edge
  always_comb begin
    state_nxt = state_r;
    wait_nxt  = 1'b1;
    rdata_nxt = rdata_r;
    unique case (state_r)
      usb_misc_pkg::BUS_IDLE: begin
        if (avs_read_in || avs_write_in) begin
          state_nxt = usb_misc_pkg::BUS_ACK;
          wait_nxt  = 1'b0;
          rdata_nxt = `RDATA_ZERO;
          if (avs_read_in) begin
            // Reads keep working under the lock
            unique case (avs_address_in)
              `OFS_SCRATCH: rdata_nxt = {16'h0000, scratch_r};
              `OFS_PULSE_W: rdata_nxt = {16'h0000, width_r};
              `OFS_TEST:    rdata_nxt = {24'h000000, test_r};
              `OFS_STATUS:  rdata_nxt = {31'h00000000, locked_r};
              default:      rdata_nxt = `RDATA_ZERO;
            endcase
          end
        end
      end
      usb_misc_pkg::BUS_ACK: begin
        state_nxt = usb_misc_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= usb_misc_pkg::BUS_IDLE;
      wait_r  <= 1'b1;
      rdata_r <= `RDATA_ZERO;
    end else begin
      state_r <= state_nxt;
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ========================================
  // Write lock
  always_comb begin
    locked_nxt = locked_r;
    if (wr_ack && key_hit) begin
      locked_nxt = 1'b0;
    end
    // Suspend entry wins over a same-cycle unlock
    if (susp_rise) begin
      locked_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      locked_r <= 1'b0;
      susp_d_r <= 1'b0;
    end else begin
      locked_r <= locked_nxt;
      susp_d_r <= suspend_in;
    end
  end

  // ========================================
  // Register writes
  always_comb begin
    scratch_nxt = scratch_r;
    width_nxt   = width_r;
    test_nxt    = test_r;
    if (bus_reset_in) begin
      test_nxt = test_r & `TEST_BUSRST_KEEP;
    end
    if (wr_ack && !locked_r) begin
      unique case (avs_address_in)
        `OFS_SCRATCH: begin
          if (avs_byteenable_in[0]) scratch_nxt[7:0] = avs_writedata_in[7:0];
          if (avs_byteenable_in[1]) scratch_nxt[15:8] = avs_writedata_in[15:8];
        end
        `OFS_PULSE_W: begin
          if (avs_byteenable_in[0]) width_nxt[7:0] = avs_writedata_in[7:0];
          if (avs_byteenable_in[1]) width_nxt[15:8] = avs_writedata_in[15:8];
        end
        `OFS_TEST: begin
          // Reserved bits are not stored and read as zero
          if (avs_byteenable_in[0]) test_nxt = avs_writedata_in[7:0] & `TEST_WR_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scratch_r <= `SCRATCH_RST;
      width_r   <= `PULSE_W_RST;
      test_r    <= `TEST_RST;
    end else begin
      scratch_r <= scratch_nxt;
      width_r   <= width_nxt;
      test_r    <= test_nxt;
    end
  end

  // ========================================
  // Speed control and line pattern select
  always_comb begin
    chirp_nxt = !(test_r[`TEST_FORCE_HS] || test_r[`TEST_FORCE_FS]);
    // Priority only matters if firmware breaks the one-bit-at-a-time limit
    if (test_r[`TEST_PSEUDO_RANDOM_PATTERN]) begin
      mode_nxt = usb_misc_pkg::LINE_PSEUDO_RANDOM_PATTERN;
    end else if (test_r[`TEST_K]) begin
      mode_nxt = usb_misc_pkg::LINE_K;
    end else if (test_r[`TEST_J]) begin
      mode_nxt = usb_misc_pkg::LINE_J;
    end else if (test_r[`TEST_NAK]) begin
      mode_nxt = usb_misc_pkg::LINE_NAK;
    end else begin
      mode_nxt = usb_misc_pkg::LINE_IDLE;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chirp_r <= 1'b1;
      mode_r  <= usb_misc_pkg::LINE_IDLE;
    end else begin
      chirp_r <= chirp_nxt;
      mode_r  <= mode_nxt;
    end
  end

  line_pattern_gen u_line (
    .clk_sys_in                   (clk_sys_in),
    .rstn_in                      (rstn_in),
    .mode_in                      (mode_r),
    .usb_data_plus_line_out       (usb_data_plus_line_out),
    .usb_data_minus_line_out      (usb_data_minus_line_out),
    .usb_data_plus_line_oe_n_out  (usb_data_plus_line_oe_n_out),
    .usb_data_minus_line_oe_n_out (usb_data_minus_line_oe_n_out),
    .quiescent_nak_out            (quiescent_nak_out)
  );

  // ========================================
  // Interrupt pulse stretcher
  // Elapsed time in ps avoids a divider; the pulse always lasts at least one cycle
  logic        irq_r;
  logic        irq_nxt;
  logic        req_d_r;
  logic [31:0] elapsed_r;
  logic [31:0] elapsed_nxt;
  logic [31:0] target;

  assign target = width_r * 32'(`PULSE_UNIT_PS);

  always_comb begin
    irq_nxt     = irq_r;
    elapsed_nxt = elapsed_r;
    if (!irq_pulse_mode_in) begin
      irq_nxt     = irq_request_in;
      elapsed_nxt = 32'h0000_0000;
    end else if (irq_r) begin
      if (elapsed_r >= target) begin
        irq_nxt = 1'b0;
      end else begin
        elapsed_nxt = elapsed_r + 32'(`CLK_PERIOD_PS);
      end
    end else if (irq_request_in && !req_d_r) begin
      irq_nxt     = 1'b1;
      elapsed_nxt = 32'(`CLK_PERIOD_PS);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_r     <= 1'b0;
      req_d_r   <= 1'b0;
      elapsed_r <= 32'h0000_0000;
    end else begin
      irq_r     <= irq_nxt;
      req_d_r   <= irq_request_in;
      elapsed_r <= elapsed_nxt;
    end
  end

  assign avs_readdata_out        = rdata_r;
  assign avs_waitrequest_out     = wait_r;
  assign irq_out                 = irq_r;
  assign force_high_speed_out    = test_r[`TEST_FORCE_HS];
  assign force_full_speed_out    = test_r[`TEST_FORCE_FS];
  assign chirp_detect_enable_out = chirp_r;
  assign writes_locked_out       = locked_r;

  // ========================================
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  AST_SCRATCH_BUSRST : assert property (bus_reset_in && !wr_ack |=> $stable(scratch_r))
    else $error("Scratch changed on bus reset");
  AST_SUSPEND_LOCKS : assert property (susp_rise |=> locked_r && writes_locked_out)
    else $error("Suspend entry did not lock writes");
  AST_UNLOCK_KEY : assert property (wr_ack && key_hit && !susp_rise |=> !locked_r)
    else $error("Unlock key did not release lock");
  AST_LOCK_DROPS : assert property (locked_r && wr_ack && !bus_reset_in |=>
    $stable(scratch_r) && $stable(width_r) && $stable(test_r))
    else $error("Write accepted while locked");
  AST_WIDTH_RESET : assert property ($rose(rstn_in) |-> width_r == `PULSE_W_RST)
    else $error("Pulse width reset value wrong");
  AST_PULSE_MIN : assert property (irq_pulse_mode_in && width_r == 16'h0001 && $rose(irq_r)
    |=> !irq_r)
    else $error("Shortest pulse longer than one cycle");
  AST_PULSE_LEN : assert property (irq_pulse_mode_in && width_r == 16'h0004 && $rose(irq_r)
    |-> irq_r [*2] ##1 !irq_r)
    else $error("Pulse of width 4 not two cycles");
  AST_FORCE_HS : assert property (test_r[`TEST_FORCE_HS] |->
    force_high_speed_out ##1 !chirp_detect_enable_out)
    else $error("Force high-speed did not stop chirp detection");
  AST_FORCE_FS : assert property (test_r[`TEST_FORCE_FS] |->
    force_full_speed_out ##1 !chirp_detect_enable_out)
    else $error("Force full-speed did not stop chirp detection");
  AST_J_STATE : assert property (test_r[3:0] == 4'h2 ##1 test_r[3:0] == 4'h2 |=>
    usb_data_plus_line_out && !usb_data_minus_line_out && !usb_data_plus_line_oe_n_out)
    else $error("J state not driven");
  AST_K_STATE : assert property (test_r[3:0] == 4'h4 ##1 test_r[3:0] == 4'h4 |=>
    !usb_data_plus_line_out && usb_data_minus_line_out && !usb_data_minus_line_oe_n_out)
    else $error("K state not driven");
  AST_NAK_STATE : assert property (test_r[3:0] == 4'h1 ##1 test_r[3:0] == 4'h1 |=>
    quiescent_nak_out && !usb_data_plus_line_out && !usb_data_minus_line_out)
    else $error("Quiescent NAK state not entered");
  AST_BUS_ONE_WAIT : assert property ((avs_read_in || avs_write_in) && wait_r
    && state_r == usb_misc_pkg::BUS_IDLE |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("Bus answer not after one wait cycle");

  COV_UNLOCK : cover property (locked_r && wr_ack && key_hit ##1 !locked_r);
  COV_PULSE : cover property (irq_pulse_mode_in && $rose(irq_r) ##[1:20] $fell(irq_r));
  COV_PSEUDO_RANDOM_PATTERN : cover property ((mode_r == usb_misc_pkg::LINE_PSEUDO_RANDOM_PATTERN) [*8]);
  COV_LOCKED_WRITE : cover property (locked_r && wr_ack && avs_address_in == `OFS_SCRATCH);
endmodule : usb_misc_regs

// file: sim/testbench.sv
// Self-checking bench for the misc register bank
`timescale 1ns/100ps
`include "usb_misc_defines.svh"
module testbench;
  // ========================================
  // Design connections
  logic                clk_sys_in;
  logic                rstn_in;
  logic [`ADDR_W-1:0]  avs_address_in;
  logic                avs_read_in;
  logic                avs_write_in;
  logic [31:0]         avs_writedata_in;
  logic [3:0]          avs_byteenable_in;
  logic [31:0]         avs_readdata_out;
  logic                avs_waitrequest_out;
  logic                suspend_in;
  logic                bus_reset_in;
  logic                irq_request_in;
  logic                irq_pulse_mode_in;
  logic                irq_out;
  logic                force_high_speed_out;
  logic                force_full_speed_out;
  logic                chirp_detect_enable_out;
  logic                writes_locked_out;
  logic                quiescent_nak_out;
  logic                usb_data_plus_line_out;
  logic                usb_data_minus_line_out;
  logic                usb_data_plus_line_oe_n_out;
  logic                usb_data_minus_line_oe_n_out;
  int                  error_cnt;
  int                  num_checks;
  int                  cycle_cnt;
  logic [31:0]         rdata;
  int                  highs;

  usb_misc_regs dut_u (
    .clk_sys_in                   (clk_sys_in),
    .rstn_in                      (rstn_in),
    .avs_address_in               (avs_address_in),
    .avs_read_in                  (avs_read_in),
    .avs_write_in                 (avs_write_in),
    .avs_writedata_in             (avs_writedata_in),
    .avs_byteenable_in            (avs_byteenable_in),
    .avs_readdata_out             (avs_readdata_out),
    .avs_waitrequest_out          (avs_waitrequest_out),
    .suspend_in                   (suspend_in),
    .bus_reset_in                 (bus_reset_in),
    .irq_request_in               (irq_request_in),
    .irq_pulse_mode_in            (irq_pulse_mode_in),
    .irq_out                      (irq_out),
    .force_high_speed_out         (force_high_speed_out),
    .force_full_speed_out         (force_full_speed_out),
    .chirp_detect_enable_out      (chirp_detect_enable_out),
    .writes_locked_out            (writes_locked_out),
    .quiescent_nak_out            (quiescent_nak_out),
    .usb_data_plus_line_out       (usb_data_plus_line_out),
    .usb_data_minus_line_out      (usb_data_minus_line_out),
    .usb_data_plus_line_oe_n_out  (usb_data_plus_line_oe_n_out),
    .usb_data_minus_line_oe_n_out (usb_data_minus_line_oe_n_out)
  );

  // ========================================
  // Clock and hang guard
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys_in) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 5000) begin
      error_cnt = error_cnt + 1;
      final_report();
    end
  end

  // ========================================
  // Checking and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus_access(input logic wr, input logic [`ADDR_W-1:0] addr,
                            input logic [31:0] wdata, input logic [3:0] be,
                            output logic [31:0] rd);
    @(posedge clk_sys_in);
    avs_address_in    <= addr;
    avs_writedata_in  <= wdata;
    avs_byteenable_in <= be;
    avs_write_in      <= wr;
    avs_read_in       <= ~wr;
    do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask : bus_access

  task automatic reg_wr(input logic [`ADDR_W-1:0] addr, input logic [15:0] d,
                        input logic [3:0] be);
    logic [31:0] unused;
    bus_access(1'b1, addr, {16'h0000, d}, be, unused);
  endtask : reg_wr

  task automatic rd_chk(input logic [`ADDR_W-1:0] addr, input logic [31:0] exp);
    logic [31:0] rd;
    bus_access(1'b0, addr, 32'h0000_0000, 4'hf, rd);
    check(rd, exp);
  endtask : rd_chk

  // Line outputs settle two cycles after the acking edge
  task automatic line_chk(input logic [7:0] mode, input logic [4:0] exp);
    reg_wr(`OFS_TEST, {8'h00, mode}, 4'h1);
    repeat (3) @(posedge clk_sys_in);
    #1;
    check({27'h0, usb_data_plus_line_out, usb_data_minus_line_out,
           usb_data_plus_line_oe_n_out, usb_data_minus_line_oe_n_out,
           quiescent_nak_out}, {27'h0, exp});
  endtask : line_chk

  // Pulse length in cycles: ceil(width * 3.33 ns / 10 ns), at least one
  task automatic pulse_chk(input logic [15:0] w);
    int exp;
    exp = (int'(w) * 333 + 999) / 1000;
    if (exp < 1) exp = 1;
    reg_wr(`OFS_PULSE_W, w, 4'h3);
    @(posedge clk_sys_in);
    irq_request_in <= 1'b1;
    highs = 0;
    repeat (40) begin
      @(posedge clk_sys_in);
      irq_request_in <= 1'b0;
      if (irq_out === 1'b1) highs = highs + 1;
    end
    check(highs, exp);
  endtask : pulse_chk

  task automatic final_report();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // ========================================
  // Test sequence
  initial begin
    error_cnt = 0;
    num_checks = 0;
    cycle_cnt = 0;
    rstn_in = 1'b0;
    avs_address_in = '0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0000_0000;
    avs_byteenable_in = 4'h0;
    suspend_in = 1'b0;
    bus_reset_in = 1'b0;
    irq_request_in = 1'b0;
    irq_pulse_mode_in = 1'b1;
    repeat (16) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    #1;
    check({28'h0, avs_waitrequest_out, chirp_detect_enable_out, writes_locked_out,
           usb_data_plus_line_oe_n_out}, 32'h0000_000d);
    // Reset values and unmapped or write-only places
    rd_chk(`OFS_SCRATCH, 32'h0000_0000);
    rd_chk(`OFS_PULSE_W, 32'h0000_001e);
    rd_chk(`OFS_TEST, 32'h0000_0000);
    rd_chk(`OFS_UNLOCK, 32'h0000_0000);
    rd_chk(10'h3fc, 32'h0000_0000);
    pulse_chk(16'h001e);
    pulse_chk(16'h0001);
    pulse_chk(16'h0004);
    // Level mode follows the request one cycle later
    irq_pulse_mode_in <= 1'b0;
    @(posedge clk_sys_in);
    irq_request_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1;
    check(irq_out, 1'b1);
    // Byte lanes of the scratch store
    reg_wr(`OFS_SCRATCH, 16'h1234, 4'h3);
    reg_wr(`OFS_SCRATCH, 16'hffab, 4'h1);
    rd_chk(`OFS_SCRATCH, 32'h0000_12ab);
    reg_wr(`OFS_SCRATCH, 16'h56ff, 4'h2);
    rd_chk(`OFS_SCRATCH, 32'h0000_56ab);
    // Bus reset keeps scratch and clears all test bits but the two force bits
    reg_wr(`OFS_TEST, 16'h0081, 4'h1);
    @(posedge clk_sys_in);
    bus_reset_in <= 1'b1;
    @(posedge clk_sys_in);
    bus_reset_in <= 1'b0;
    rd_chk(`OFS_TEST, 32'h0000_0080);
    rd_chk(`OFS_SCRATCH, 32'h0000_56ab);
    // Speed forcing and chirp detection
    line_chk(8'h00, 5'b00110);
    reg_wr(`OFS_TEST, 16'h0080, 4'h1);
    repeat (2) @(posedge clk_sys_in);
    #1;
    check({force_high_speed_out, force_full_speed_out, chirp_detect_enable_out}, 3'b100);
    reg_wr(`OFS_TEST, 16'h0010, 4'h1);
    repeat (2) @(posedge clk_sys_in);
    #1;
    check({force_high_speed_out, force_full_speed_out, chirp_detect_enable_out}, 3'b010);
    reg_wr(`OFS_TEST, 16'h0000, 4'h1);
    repeat (2) @(posedge clk_sys_in);
    #1;
    check(chirp_detect_enable_out, 1'b1);
    // Line states: plus, minus, enable pair, quiescent flag
    line_chk(8'h02, 5'b10000);
    line_chk(8'h04, 5'b01000);
    line_chk(8'h01, 5'b00001);
    reg_wr(`OFS_TEST, 16'h0008, 4'h1);
    // Pattern reaches the lines two cycles after the acking edge
    @(posedge clk_sys_in);
    highs = 0;
    repeat (40) begin
      @(posedge clk_sys_in);
      #1;
      check(usb_data_minus_line_out, !usb_data_plus_line_out);
      if (usb_data_plus_line_out === 1'b1) highs = highs + 1;
    end
    check(highs > 0 && highs < 40, 1'b1);
    check(usb_data_plus_line_oe_n_out, 1'b0);
    reg_wr(`OFS_TEST, 16'h0000, 4'h1);
    // Suspend locks writes; reads still served
    @(posedge clk_sys_in);
    suspend_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    suspend_in <= 1'b0;
    #1;
    check(writes_locked_out, 1'b1);
    rd_chk(`OFS_STATUS, 32'h0000_0001);
    reg_wr(`OFS_SCRATCH, 16'h5555, 4'h3);
    reg_wr(`OFS_PULSE_W, 16'h0002, 4'h3);
    reg_wr(`OFS_TEST, 16'h0080, 4'h1);
    rd_chk(`OFS_SCRATCH, 32'h0000_56ab);
    rd_chk(`OFS_PULSE_W, 32'h0000_0004);
    rd_chk(`OFS_TEST, 32'h0000_0000);
    reg_wr(`OFS_UNLOCK, 16'haa36, 4'h3);
    reg_wr(`OFS_UNLOCK, 16'haa37, 4'h1);
    rd_chk(`OFS_STATUS, 32'h0000_0001);
    reg_wr(`OFS_UNLOCK, 16'haa37, 4'h3);
    rd_chk(`OFS_STATUS, 32'h0000_0000);
    check(writes_locked_out, 1'b0);
    reg_wr(`OFS_SCRATCH, 16'h5555, 4'h3);
    rd_chk(`OFS_SCRATCH, 32'h0000_5555);
    final_report();
  end
endmodule : testbench
